// *** logic/swpra_top.sv ***
// Purpose: Register access to the per-port PHY window of a switch.
// Assumes: Requests arrive already decoded from any management path.
// Notes:   One request per cycle; answer one cycle later.
// How it works
// - Each port's PHY registers sit at bytes 0xN100..0xN13F, N the port.
// - Lower window takes 8- or 16-bit writes, touching only those bytes.
// - Upper-window writes off MDIO act 32-bit; each unaddressed byte gets zero.
// - Reads of any width return true contents; widening hits writes only.
// - Bit 11 of each basic control powers that PHY down.
// - EEE advertised at reset; active only when negotiated by both ends.
// - Auto edge mode measures serial clock once and never re-adapts.
// - Every port is reachable over MDIO, I2C, SPI or in-band.
// - Registers 0x0..0x1F direct; MMD space via setup and data registers.
`timescale 1ns/1ps

module swpra_top
  import swpra_pkg::*;
#(
  parameter int NUM_PORTS = `SWPRA_NUM_PORTS
) (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_req,
  input  wire logic                 i_wr,
  input  wire swpra_path_e          i_path,
  input  wire logic [15:0]          i_addr,
  input  wire logic [3:0]           i_be,
  input  wire logic [31:0]          i_wdata,
  input  wire logic [NUM_PORTS-1:0] i_partner_eee,
  input  wire logic                 i_spi_sclk,
  output logic                      o_ack,
  output logic [31:0]               o_rdata,
  output logic [NUM_PORTS-1:0]      o_phy_pwrdn,
  output logic [NUM_PORTS-1:0]      o_eee_active,
  output logic                      o_spi_edge
);

  localparam int AW = 7;

  swpra_state_s st_r;
  swpra_state_s st_nxt;
  swpra_mem_if #(.AW(AW)) mem ();

  logic       hit;
  logic       upper;
  logic [3:0] word;
  logic [2:0] pidx;
  logic       gcfg;
  logic       rise;

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // True when an address lands in a port's PHY window
  function automatic logic win_hit(input logic [15:0] a);
    win_hit = (a[15:12] >= 4'h1)
           && (a[15:12] <= 4'(NUM_PORTS))
           && (a[11:0] >= `SWPRA_WIN_BASE)
           && (a[11:0] <= `SWPRA_WIN_LAST);
  endfunction

  // Byte merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0]  be);
    merge16 = {be[1] ? nw[15:8] : old[15:8],
               be[0] ? nw[7:0]  : old[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Address decode
  always_comb begin
    hit   = win_hit(i_addr);
    upper = i_addr[5];
    word  = i_addr[5:2];
    pidx  = 3'(i_addr[15:12] - 4'h1);
    gcfg  = (i_addr == {4'h0, `SWPRA_EDGE_CFG});
    rise  = i_spi_sclk && !st_r.sclk_d;
  end

  ////////////////////////////////////////////////////////////////////
  // Next state and store access
  always_comb begin
    st_nxt          = st_r;
    st_nxt.ack      = i_req;
    st_nxt.ovr_lo   = 1'b0;
    st_nxt.ovr_hi   = 1'b0;
    st_nxt.ovr_data = '0;
    st_nxt.sclk_d   = i_spi_sclk;
    mem.addr        = {pidx, word};
    mem.we          = 1'b0;
    mem.be          = i_be;
    mem.wdata       = i_wdata;

    // Widened writes in the upper window, MDIO path excepted
    if (upper && i_path != SWPRA_PATH_MDIO) begin
      mem.be = 4'hf;
      for (int b = 0; b < 4; b++) begin
        if (!i_be[b]) begin
          mem.wdata[8*b +: 8] = 8'h00;
        end
      end
    end

    if (i_req && i_wr && hit) begin
      mem.we = 1'b1;
      // Basic control shadow, drives power-down and negotiation
      if (word == `SWPRA_WORD_BCTRL) begin
        st_nxt.bctrl[pidx] = merge16(st_r.bctrl[pidx],
                                     mem.wdata[15:0], mem.be[1:0]);
      end
      // Indirect setup register: function and device
      if (word == `SWPRA_WORD_MMD_SETUP && mem.be[3]) begin
        st_nxt.mmd_setup[pidx][6:5] = mem.wdata[31:30];
      end
      if (word == `SWPRA_WORD_MMD_SETUP && mem.be[2]) begin
        st_nxt.mmd_setup[pidx][4:0] = mem.wdata[20:16];
      end
      // Indirect data register: address or data phase
      if (word == `SWPRA_WORD_MMD_DATA && mem.be[1:0] != 2'b00) begin
        if (st_r.mmd_setup[pidx][6:5] == 2'b00) begin
          st_nxt.mmd_addr[pidx] = merge16(st_r.mmd_addr[pidx],
                                          mem.wdata[15:0], mem.be[1:0]);
        end else if (st_r.mmd_setup[pidx][4:0] == `SWPRA_EEE_DEV
                  && st_r.mmd_addr[pidx] == `SWPRA_EEE_REG
                  && mem.be[0]) begin
          st_nxt.eee_adv[pidx] = mem.wdata[2:1];
        end
      end
    end

    // Global edge configuration write
    if (i_req && i_wr && gcfg && i_be[0]) begin
      st_nxt.edge_cfg = i_wdata[7:0];
    end

    // Read answers: shadowed halves replace store data
    if (i_req && !i_wr) begin
      if (!hit) begin
        st_nxt.ovr_lo = 1'b1;
        st_nxt.ovr_hi = 1'b1;
        if (gcfg) begin
          st_nxt.ovr_data = {24'h0, st_r.edge_cfg};
        end
      end else if (word == `SWPRA_WORD_BCTRL) begin
        st_nxt.ovr_lo         = 1'b1;
        st_nxt.ovr_data[15:0] = st_r.bctrl[pidx];
      end else if (word == `SWPRA_WORD_MMD_SETUP) begin
        st_nxt.ovr_hi          = 1'b1;
        st_nxt.ovr_data[31:16] = {st_r.mmd_setup[pidx][6:5], 9'h000,
                                  st_r.mmd_setup[pidx][4:0]};
      end else if (word == `SWPRA_WORD_MMD_DATA) begin
        st_nxt.ovr_lo = 1'b1;
        if (st_r.mmd_setup[pidx][6:5] == 2'b00) begin
          st_nxt.ovr_data[15:0] = st_r.mmd_addr[pidx];
        end else if (st_r.mmd_setup[pidx][4:0] == `SWPRA_EEE_DEV
                  && st_r.mmd_addr[pidx] == `SWPRA_EEE_REG) begin
          st_nxt.ovr_data[15:0] = {13'h0, st_r.eee_adv[pidx], 1'b0};
        end
      end
    end

    // One-time serial clock period measurement
    if (st_r.edge_cfg[`SWPRA_EDGE_AUTO_BIT] && !st_r.measured) begin
      if (st_r.meas_cnt != 8'hff) begin
        st_nxt.meas_cnt = st_r.meas_cnt + 8'h01;
      end
      if (rise) begin
        st_nxt.meas_cnt = 8'h00;
        st_nxt.armed    = 1'b1;
        if (st_r.armed) begin
          st_nxt.measured  = 1'b1;
          st_nxt.edge_meas = (st_r.meas_cnt
                              < 8'(`SWPRA_EDGE_THR_CYC - 1));
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_r          <= '0;
      st_r.edge_cfg <= `SWPRA_EDGE_CFG_RST;
      for (int p = 0; p < NUM_PORTS; p++) begin
        st_r.bctrl[p]   <= `SWPRA_BCTRL_RST;
        st_r.eee_adv[p] <= `SWPRA_EEE_RST;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Word store
  swpra_store #(.AW(AW)) u_store (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .m         (mem)
  );

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_ack   = st_r.ack;
  assign o_rdata = {st_r.ovr_hi ? st_r.ovr_data[31:16] : mem.rdata[31:16],
                    st_r.ovr_lo ? st_r.ovr_data[15:0]  : mem.rdata[15:0]};
  assign o_spi_edge = (st_r.edge_cfg[`SWPRA_EDGE_AUTO_BIT]
                       && st_r.measured)
                    ? st_r.edge_meas
                    : st_r.edge_cfg[`SWPRA_EDGE_MAN_BIT];

  // Per-port power-down and energy-efficient activation
  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
    assign o_phy_pwrdn[g]  = st_r.bctrl[g][`SWPRA_PWRDN_BIT];
    assign o_eee_active[g] = (st_r.eee_adv[g] != 2'b00)
                          && st_r.bctrl[g][`SWPRA_ANEN_BIT]
                          && i_partner_eee[g];
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence s_bctrl_wr;
    i_req && i_wr && win_hit(i_addr) && i_addr[5:2] == 4'h0
      && i_be[1];
  endsequence

  a_ack_timing: assert property (i_req |=> o_ack)
    else $error("answer not one cycle after request");
  a_window_decode: assert property (
    i_req && i_wr && !win_hit(i_addr) |-> !mem.we)
    else $error("store written outside window");
  a_lower_lanes: assert property (
    i_req && i_wr && win_hit(i_addr) && !i_addr[5]
      |-> mem.be == i_be)
    else $error("lower window lanes altered");
  a_upper_widen: assert property (
    i_req && i_wr && win_hit(i_addr) && i_addr[5]
      && i_path != SWPRA_PATH_MDIO
      |-> mem.be == 4'hf && (i_be[0] || mem.wdata[7:0] == 8'h00))
    else $error("upper write not widened");
  a_mdio_direct: assert property (
    i_req && i_wr && i_path == SWPRA_PATH_MDIO |-> mem.be == i_be)
    else $error("mdio write widened");
  a_pwrdn_write: assert property (
    s_bctrl_wr |=> o_phy_pwrdn[$past(pidx)]
                   == $past(i_wdata[`SWPRA_PWRDN_BIT]))
    else $error("power-down not following write");
  a_eee_needs_an: assert property (
    o_eee_active[1] |-> st_r.bctrl[1][`SWPRA_ANEN_BIT]
                        && i_partner_eee[1])
    else $error("eee active without negotiation");
  a_eee_reset: assert property (
    $past(i_rst) |-> st_r.eee_adv[0] == `SWPRA_EEE_RST)
    else $error("eee not advertised after reset");
  a_edge_hold: assert property (
    st_r.measured && $past(st_r.measured) && $stable(st_r.edge_cfg)
      |-> $stable(o_spi_edge))
    else $error("edge re-adapted after measurement");
  a_pair_write: assert property (
    i_req && i_wr && win_hit(i_addr) && i_be == 4'hf
      ##2 i_req && !i_wr && !$past(i_req)
      && $past(i_addr, 2) == i_addr && i_addr[5:2] > 4'h7
      |=> o_rdata == $past(i_wdata, 3))
    else $error("pair write not seen whole");

endmodule

// *** pkg/swpra_regs.svh ***
// Purpose: Offsets, field positions, reset values and timing counts
//          of the switch PHY register access block.
// Assumes: Byte addresses are 16 bits; the top nibble is the port.
// Notes:   Definitions only.
`ifndef SWPRA_REGS_SVH
`define SWPRA_REGS_SVH

// Ports and PHY window
`define SWPRA_NUM_PORTS      5
`define SWPRA_WIN_BASE       12'h100
`define SWPRA_WIN_LAST       12'h13f
`define SWPRA_WORD_BCTRL     4'h0
`define SWPRA_WORD_MMD_SETUP 4'h6
`define SWPRA_WORD_MMD_DATA  4'h7

// Global output edge configuration register
`define SWPRA_EDGE_CFG       12'h100
`define SWPRA_EDGE_CFG_RST   8'h02
`define SWPRA_EDGE_AUTO_BIT  1
`define SWPRA_EDGE_MAN_BIT   0

// Basic control fields
`define SWPRA_BCTRL_RST      16'h1140
`define SWPRA_PWRDN_BIT      11
`define SWPRA_ANEN_BIT       12

// Indirect energy-efficient advertisement register
`define SWPRA_EEE_DEV        5'h07
`define SWPRA_EEE_REG        16'h003c
`define SWPRA_EEE_RST        2'h3

// Timing: serial clock period that separates slow from fast
`define SWPRA_CLK_NS         4
`define SWPRA_EDGE_THR_NS    40
`define SWPRA_EDGE_THR_CYC   ((`SWPRA_EDGE_THR_NS) / (`SWPRA_CLK_NS))

`endif

// *** pkg/swpra_pkg.sv ***
// Purpose: Types of the switch PHY register access block.
// Assumes: Constants come from swpra_regs.svh.
// Notes:   The state struct is sized by the default port count.
`include "swpra_regs.svh"

package swpra_pkg;

  // Management path that carried a request
  typedef enum logic [1:0] {
    SWPRA_PATH_SPI,
    SWPRA_PATH_I2C,
    SWPRA_PATH_MDIO,
    SWPRA_PATH_INBAND
  } swpra_path_e;

  // All state of the control module
  typedef struct packed {
    logic [`SWPRA_NUM_PORTS-1:0][15:0] bctrl;
    logic [`SWPRA_NUM_PORTS-1:0][1:0]  eee_adv;
    logic [`SWPRA_NUM_PORTS-1:0][6:0]  mmd_setup;
    logic [`SWPRA_NUM_PORTS-1:0][15:0] mmd_addr;
    logic [7:0]                        edge_cfg;
    logic                              sclk_d;
    logic                              armed;
    logic                              measured;
    logic                              edge_meas;
    logic [7:0]                        meas_cnt;
    logic                              ack;
    logic                              ovr_lo;
    logic                              ovr_hi;
    logic [31:0]                       ovr_data;
  } swpra_state_s;

  // State of the word store
  typedef struct packed {
    logic [31:0] rdata;
  } swpra_mem_state_s;

endpackage

// *** pkg/swpra_mem_if.sv ***
// Purpose: Word store port between control logic and the store.
// Assumes: One access per cycle, read data one cycle later.
// Notes:   Byte lane 0 is bits 7:0.
`timescale 1ns/1ps

interface swpra_mem_if #(
  parameter int AW = 7
);
  logic          we;
  logic [AW-1:0] addr;
  logic [3:0]    be;
  logic [31:0]   wdata;
  logic [31:0]   rdata;

  modport ctrl (output we, output addr, output be, output wdata,
                input rdata);
  modport store (input we, input addr, input be, input wdata,
                 output rdata);
endinterface

// *** logic/swpra_store.sv ***
// Purpose: Word store holding the PHY register window of every port.
// Assumes: Contents are data, not control, and are not reset.
// Notes:   Read data come out of a register.
`timescale 1ns/1ps

module swpra_store
  import swpra_pkg::*;
#(
  parameter int AW = 7
) (
  input  wire logic  i_sys_clk,
  input  wire logic  i_rst,
  swpra_mem_if.store m
);

  logic [3:0][7:0]  mem_q [0:(1<<AW)-1];
  swpra_mem_state_s st_r;
  swpra_mem_state_s st_nxt;

  ////////////////////////////////////////////////////////////////////
  // Read data register
  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = mem_q[m.addr];
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Byte-lane writes, all enabled lanes in one edge
  always_ff @(posedge i_sys_clk) begin
    for (int b = 0; b < 4; b++) begin
      if (m.we && m.be[b]) begin
        mem_q[m.addr][b] <= m.wdata[8*b +: 8];
      end
    end
  end

  assign m.rdata = st_r.rdata;

endmodule

// *** tb/swpra_host.sv ***
// Purpose: Management host model that issues register requests.
// Assumes: One request at a time, answer within a few cycles.
// Notes:   Released address and data lines show inverted last values.
`timescale 1ns/1ps

module swpra_host
  import swpra_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_rdata,
  output logic             o_req,
  output logic             o_wr,
  output swpra_path_e      o_path,
  output logic [15:0]      o_addr,
  output logic [3:0]       o_be,
  output logic [31:0]      o_wdata
);
  ////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    o_req   = 1'b0;
    o_wr    = 1'b0;
    o_path  = SWPRA_PATH_SPI;
    o_addr  = 16'h0000;
    o_be    = 4'h0;
    o_wdata = 32'h0000_0000;
  end

  // One request pulse, then a bounded wait for the answer
  task automatic access(input logic wr, input swpra_path_e path,
                        input logic [15:0] addr, input logic [3:0] be,
                        input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic ok);
    int n;
    @(posedge i_sys_clk);
    o_req   <= 1'b1;
    o_wr    <= wr;
    o_path  <= path;
    o_addr  <= addr;
    o_be    <= be;
    o_wdata <= wdata;
    @(posedge i_sys_clk);
    o_req   <= 1'b0;
    o_addr  <= ~addr;
    o_wdata <= ~wdata;
    #1;
    n = 0;
    while (i_ack !== 1'b1 && n < 4) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    ok    = (i_ack === 1'b1);
    rdata = i_rdata;
  endtask

  // Upper window: read the pair, merge, write all four lanes
  task automatic rmw(input swpra_path_e path, input logic [15:0] addr,
                     input logic [31:0] data, input logic [31:0] keep,
                     output logic ok);
    logic [31:0] cur;
    logic        ok1;
    access(1'b0, path, {addr[15:2], 2'b00}, 4'hf, 32'h0, cur, ok1);
    access(1'b1, path, {addr[15:2], 2'b00}, 4'hf,
           (cur & keep) | (data & ~keep), cur, ok);
    ok = ok & ok1;
  endtask
endmodule

// *** tb/test_swpra_top.sv ***
// Purpose: Self-checking bench of the PHY register access block.
// Assumes: Answer one cycle after each request.
// Notes:   Table rows first, then power, EEE, edge and reset cases.
`timescale 1ns/1ps

module test_swpra_top
  import swpra_pkg::*;
;
  typedef struct {
    logic        wr;
    swpra_path_e p;
    logic [15:0] a;
    logic [3:0]  be;
    logic [31:0] d;
    logic [31:0] m;
  } swpra_row_s;

  logic        sys_clk;
  logic        rst;
  logic        req;
  logic        wr;
  swpra_path_e path;
  logic [15:0] addr;
  logic [3:0]  be;
  logic [31:0] wdata;
  logic [4:0]  partner_eee;
  logic        sclk;
  logic        ack;
  logic [31:0] rdata;
  logic [4:0]  pwrdn;
  logic [4:0]  eee;
  logic        spi_edge;
  logic [31:0] r;
  logic        ok;
  int          bad_count;
  int          checked;

  // Reads carry the expected word masked by m; writes have m zero
  swpra_row_s rows [18] = '{
    '{0, SWPRA_PATH_SPI,    16'h1100, 4'hf, 32'h1140, 32'hffff},
    '{0, SWPRA_PATH_I2C,    16'h0100, 4'hf, 32'h02,   32'hff},
    '{1, SWPRA_PATH_SPI,    16'h1100, 4'h3, 32'h2100, 32'h0},
    '{0, SWPRA_PATH_MDIO,   16'h1100, 4'h3, 32'h2100, 32'hffff},
    '{1, SWPRA_PATH_SPI,    16'h1108, 4'hf, 32'h12345678, 32'h0},
    '{1, SWPRA_PATH_I2C,    16'h1108, 4'h1, 32'h000000aa, 32'h0},
    '{0, SWPRA_PATH_INBAND, 16'h1108, 4'hf, 32'h123456aa, '1},
    '{1, SWPRA_PATH_SPI,    16'h1120, 4'hf, 32'haaaabbbb, 32'h0},
    '{1, SWPRA_PATH_SPI,    16'h1120, 4'hc, 32'h55550000, 32'h0},
    '{0, SWPRA_PATH_SPI,    16'h1120, 4'h3, 32'h55550000, '1},
    '{1, SWPRA_PATH_MDIO,   16'h5124, 4'hf, 32'h11112222, 32'h0},
    '{1, SWPRA_PATH_MDIO,   16'h5124, 4'h3, 32'h00003333, 32'h0},
    '{0, SWPRA_PATH_I2C,    16'h5124, 4'hf, 32'h11113333, '1},
    '{1, SWPRA_PATH_INBAND, 16'h513c, 4'h3, 32'h0000cafe, 32'h0},
    '{0, SWPRA_PATH_SPI,    16'h513c, 4'hf, 32'h0000cafe, '1},
    '{1, SWPRA_PATH_SPI,    16'h6100, 4'h3, 32'h00001234, 32'h0},
    '{0, SWPRA_PATH_SPI,    16'h6100, 4'hf, 32'h0, '1},
    '{0, SWPRA_PATH_SPI,    16'h1140, 4'hf, 32'h0, '1}
  };

  ////////////////////////////////////////////////////////////////////////
  swpra_host swpra_host_i (
    .i_sys_clk (sys_clk),
    .i_ack     (ack),
    .i_rdata   (rdata),
    .o_req     (req),
    .o_wr      (wr),
    .o_path    (path),
    .o_addr    (addr),
    .o_be      (be),
    .o_wdata   (wdata)
  );

  swpra_top swpra_top_i (
    .i_sys_clk     (sys_clk),
    .i_rst         (rst),
    .i_req         (req),
    .i_wr          (wr),
    .i_path        (path),
    .i_addr        (addr),
    .i_be          (be),
    .i_wdata       (wdata),
    .i_partner_eee (partner_eee),
    .i_spi_sclk    (sclk),
    .o_ack         (ack),
    .o_rdata       (rdata),
    .o_phy_pwrdn   (pwrdn),
    .o_eee_active  (eee),
    .o_spi_edge    (spi_edge)
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Compare one result word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Print counts and verdict, then end the run
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Request through the host; a missing answer ends the run
  task automatic acc(input logic w, input swpra_path_e p,
                     input logic [15:0] a, input logic [3:0] b,
                     input logic [31:0] d);
    swpra_host_i.access(w, p, a, b, d, r, ok);
    if (ok !== 1'b1) begin
      bad_count++;
      $display("Error at %0t: no answer", $time);
      stop_test();
    end
  endtask

  // Edge configuration write followed by the chosen edge
  task automatic set_edge(input logic [7:0] v, input logic exp);
    acc(1'b1, SWPRA_PATH_SPI, 16'h0100, 4'h1, {24'h0, v});
    chk({31'h0, spi_edge}, {31'h0, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst         = 1'b1;
    partner_eee = 5'b00010;
    sclk        = 1'b0;
    bad_count   = 0;
    checked     = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    chk({27'h0, eee}, 32'h2);
    foreach (rows[i]) begin
      acc(rows[i].wr, rows[i].p, rows[i].a, rows[i].be, rows[i].d);
      chk(r & rows[i].m, rows[i].d & rows[i].m);
    end
    $display("table test done");
    // Upper pair merge keeps the neighbour half
    swpra_host_i.rmw(SWPRA_PATH_SPI, 16'h5130, 32'h0000_1111, 32'h0, ok);
    chk({31'h0, ok}, 32'h1);
    swpra_host_i.rmw(SWPRA_PATH_SPI, 16'h5130, 32'h2222_0000,
                     32'h0000_ffff, ok);
    chk({31'h0, ok}, 32'h1);
    acc(1'b0, SWPRA_PATH_SPI, 16'h5130, 4'hf, 32'h0);
    chk(r, 32'h2222_0000 | (32'h1111 & '1));
    // Power-down per port, no link anywhere
    acc(1'b1, SWPRA_PATH_SPI, 16'h3100, 4'h3, 32'h0900);
    chk({27'h0, pwrdn}, 32'h04);
    acc(1'b1, SWPRA_PATH_I2C, 16'h3100, 4'h3, 32'h0100);
    chk({27'h0, pwrdn}, 32'h00);
    $display("power test done");
    // EEE: force 100M, clear advert through indirect space, restart
    acc(1'b1, SWPRA_PATH_SPI, 16'h2100, 4'h3, 32'h2100);
    chk({27'h0, eee}, 32'h0);
    acc(1'b1, SWPRA_PATH_SPI, 16'h2118, 4'hc, 32'h0007_0000);
    acc(1'b1, SWPRA_PATH_SPI, 16'h211c, 4'h3, 32'h003c);
    acc(1'b1, SWPRA_PATH_SPI, 16'h2118, 4'hc, 32'h4007_0000);
    acc(1'b0, SWPRA_PATH_MDIO, 16'h211c, 4'hf, 32'h0);
    chk(r & 32'hffff, 32'h0006);
    acc(1'b1, SWPRA_PATH_MDIO, 16'h211c, 4'h3, 32'h0000);
    acc(1'b0, SWPRA_PATH_SPI, 16'h211c, 4'hf, 32'h0);
    chk(r & 32'hffff, 32'h0000);
    acc(1'b1, SWPRA_PATH_SPI, 16'h2100, 4'h3, 32'h1340);
    chk({27'h0, eee}, 32'h0);
    $display("eee test done");
    // Initialisation value into indirect device 0x1c on every port
    for (int p = 1; p <= 5; p++) begin
      acc(1'b1, SWPRA_PATH_SPI, {4'(p), 12'h100}, 4'h3, 32'h2100);
      acc(1'b1, SWPRA_PATH_SPI, {4'(p), 12'h118}, 4'hc, 32'h001c_0000);
      acc(1'b1, SWPRA_PATH_SPI, {4'(p), 12'h11c}, 4'h3, 32'h0004);
      acc(1'b1, SWPRA_PATH_SPI, {4'(p), 12'h118}, 4'hc, 32'h401c_0000);
      acc(1'b1, SWPRA_PATH_I2C, {4'(p), 12'h11c}, 4'h3, 32'h00d0);
      acc(1'b0, SWPRA_PATH_SPI, {4'(p), 12'h11c}, 4'hf, 32'h0);
      chk(r & 32'hffff, 32'h0);
      acc(1'b1, SWPRA_PATH_SPI, {4'(p), 12'h100}, 4'h3, 32'h1340);
    end
    chk({27'h0, eee}, 32'h0);
    $display("mmd init test done");
    // Fast serial clock measured once, then a slow one ignored
    chk({31'h0, spi_edge}, 32'h0);
    repeat (12) begin
      repeat (2) @(posedge sys_clk);
      sclk <= ~sclk;
    end
    repeat (2) @(posedge sys_clk);
    #1 chk({31'h0, spi_edge}, 32'h1);
    repeat (8) begin
      repeat (10) @(posedge sys_clk);
      sclk <= ~sclk;
    end
    repeat (2) @(posedge sys_clk);
    #1 chk({31'h0, spi_edge}, 32'h1);
    set_edge(8'h00, 1'b0);
    set_edge(8'h01, 1'b1);
    set_edge(8'h02, 1'b1);
    $display("edge test done");
    // Second reset in mid-run
    acc(1'b1, SWPRA_PATH_SPI, 16'h5100, 4'h3, 32'h0900);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    #1 chk({26'h0, pwrdn, spi_edge}, 32'h0);
    acc(1'b0, SWPRA_PATH_SPI, 16'h1100, 4'hf, 32'h0);
    chk(r & 32'hffff, 32'h1140);
    acc(1'b0, SWPRA_PATH_SPI, 16'h0100, 4'hf, 32'h0);
    chk(r & 32'hff, 32'h02);
    $display("reset test done");
    stop_test();
  end
endmodule
